//--- rtl/mission_status_registers.v
// mission status and bookkeeping register bank of a temperature logger
// Functional notes
// - alarm flags read-only; bits 6:4 one, 3:2 zero
// - memory clear clears all alarm flags together
// - low flag sets on conversion at/below threshold
// - high flag sets on conversion at/above threshold
// - forced conversion and initial alarm also set flags
// - battery reset alarm reads one after power-on reset
// - state register read-only; fixed bits 0,2,5 zero, 7:6 one
// - mission active while running; clears on mission end
// - memory clear wipes alarms; with no mission active it also wipes stamp, count and sets cleared
// - cleared indicator drops on mission start
// - mission start refused unless memory was cleared
// - waiting flag set on alarm-triggered start success
// - waiting flag cleared only by temperature alarm
// - wait programmed minutes before logging or alarm test
// - start delay is 24-bit, low byte lowest address
// - delay writes ignored while mission in progress
// - delay expires before alarm testing begins
// - capture clock time of first mission sample
// - stamp bytes are BCD with hour and century bits
// - alarm start logs one period after alarm
`timescale 1ns/1ps
`include "mission_status_defines.vh"
module mission_status_registers #(
  parameter ADDR_WIDTH = 10,
  parameter DELAY_WIDTH = 24
) (
  input wire ref_clk,
  input wire rst,
  input wire powerOnReset,
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWriteData,
  input wire clearMemoryCmd,
  input wire startMissionCmd,
  input wire stopMissionCmd,
  input wire alarmTriggeredStart,
  input wire minuteTick,
  input wire sampleTick,
  input wire conversionDone,
  input wire forcedConversion,
  input wire lowAlarmHit,
  input wire highAlarmHit,
  input wire [47:0] rtcTime,
  output reg [7:0] regReadData,
  output reg startRefused,
  output reg loggingEnable,
  output reg alarmTestEnable,
  output reg sampleCountClear
);

  // ************************************************************
  // state
  // ************************************************************
  localparam PH_IDLE = 2'd0;
  localparam PH_DELAY = 2'd1;
  localparam PH_ALARM_TEST = 2'd2;
  localparam PH_LOGGING = 2'd3;

  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  reg lowTemp_reg;
  reg highTemp_reg;
  reg batteryReset_reg;
  reg missionActive_reg;
  reg memoryCleared_reg;
  reg waitingAlarm_reg;
  reg firstSampleDue_reg;
  reg armLogging_reg;
  reg [DELAY_WIDTH-1:0] delay_reg;
  reg [DELAY_WIDTH-1:0] delayCount_reg;
  reg [47:0] stamp_reg;

  wire startOk = startMissionCmd && !missionActive_reg && memoryCleared_reg;
  wire missionConv = conversionDone && missionActive_reg &&
    (phase_reg == PH_ALARM_TEST || phase_reg == PH_LOGGING);
  wire flagConv = missionConv || forcedConversion;
  wire alarmEvent = flagConv && (lowAlarmHit || highAlarmHit);

  // ************************************************************
  // mission sequencing
  // ************************************************************
  always @* begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (startOk) begin
          if (delay_reg != {DELAY_WIDTH{1'b0}}) begin
            phase_next = PH_DELAY;
          end else if (alarmTriggeredStart) begin
            phase_next = PH_ALARM_TEST;
          end else begin
            phase_next = PH_LOGGING;
          end
        end
      end
      PH_DELAY: begin
        // alarm testing only after the delay runs out
        if (minuteTick && delayCount_reg <= {{(DELAY_WIDTH-1){1'b0}}, 1'b1}) begin
          phase_next = alarmTriggeredStart ? PH_ALARM_TEST : PH_LOGGING;
        end
      end
      PH_ALARM_TEST: begin
        if (armLogging_reg && sampleTick) begin
          phase_next = PH_LOGGING;
        end
      end
      PH_LOGGING: begin
        phase_next = PH_LOGGING;
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
    if (stopMissionCmd) begin
      phase_next = PH_IDLE;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= PH_IDLE;
      delayCount_reg <= {DELAY_WIDTH{1'b0}};
      missionActive_reg <= 1'b0;
      armLogging_reg <= 1'b0;
      firstSampleDue_reg <= 1'b0;
      loggingEnable <= 1'b0;
      alarmTestEnable <= 1'b0;
      startRefused <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      startRefused <= startMissionCmd && !startOk;
      if (startOk) begin
        delayCount_reg <= delay_reg;
      end else if (phase_reg == PH_DELAY && minuteTick) begin
        delayCount_reg <= delayCount_reg - {{(DELAY_WIDTH-1){1'b0}}, 1'b1};
      end
      if (stopMissionCmd) begin
        missionActive_reg <= 1'b0;
      end else if (startOk) begin
        missionActive_reg <= 1'b1;
      end
      // the alarm conversion is not logged; the next sample period is
      if (phase_reg == PH_ALARM_TEST && missionConv && (lowAlarmHit || highAlarmHit)) begin
        armLogging_reg <= 1'b1;
      end else if (phase_reg != PH_ALARM_TEST) begin
        armLogging_reg <= 1'b0;
      end
      if (startOk) begin
        firstSampleDue_reg <= 1'b1;
      end else if (phase_reg == PH_LOGGING && conversionDone) begin
        firstSampleDue_reg <= 1'b0;
      end
      loggingEnable <= (phase_next == PH_LOGGING);
      alarmTestEnable <= (phase_next == PH_ALARM_TEST);
    end
  end

  // ************************************************************
  // flags, delay and stamp
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      lowTemp_reg <= 1'b0;
      highTemp_reg <= 1'b0;
      batteryReset_reg <= 1'b0;
      memoryCleared_reg <= 1'b0;
      waitingAlarm_reg <= 1'b0;
      delay_reg <= {DELAY_WIDTH{1'b0}};
      stamp_reg <= 48'h000000000000;
      sampleCountClear <= 1'b0;
    end else begin
      // set wins over the clear when both land in one cycle
      if (flagConv && lowAlarmHit) begin
        lowTemp_reg <= 1'b1;
      end else if (clearMemoryCmd) begin
        lowTemp_reg <= 1'b0;
      end
      if (flagConv && highAlarmHit) begin
        highTemp_reg <= 1'b1;
      end else if (clearMemoryCmd) begin
        highTemp_reg <= 1'b0;
      end
      if (powerOnReset) begin
        batteryReset_reg <= 1'b1;
      end else if (clearMemoryCmd) begin
        batteryReset_reg <= 1'b0;
      end
      if (clearMemoryCmd && !missionActive_reg) begin
        memoryCleared_reg <= 1'b1;
      end else if (startOk) begin
        memoryCleared_reg <= 1'b0;
      end
      // memory clearing leaves this one alone on purpose
      if (startOk && alarmTriggeredStart) begin
        waitingAlarm_reg <= 1'b1;
      end else if (alarmEvent) begin
        waitingAlarm_reg <= 1'b0;
      end
      if (regWrite && !missionActive_reg) begin
        case (regAddr)
          `ADDR_DELAY_LOW: delay_reg[7:0] <= regWriteData;
          `ADDR_DELAY_MID: delay_reg[15:8] <= regWriteData;
          `ADDR_DELAY_HIGH: delay_reg[23:16] <= regWriteData;
          default: begin
          end
        endcase
      end
      if (clearMemoryCmd && !missionActive_reg) begin
        stamp_reg <= 48'h000000000000;
      end else if (firstSampleDue_reg && phase_reg == PH_LOGGING && conversionDone) begin
        stamp_reg <= rtcTime;
      end
      sampleCountClear <= clearMemoryCmd && !missionActive_reg;
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always @(posedge ref_clk) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else begin
      case (regAddr)
        `ADDR_ALARM_FLAGS: regReadData <= `ALARM_FIXED_ONES | {batteryReset_reg, 5'h00, highTemp_reg,
          lowTemp_reg};
        `ADDR_MISSION_STATE: regReadData <= `STATE_FIXED_ONES | {3'h0, waitingAlarm_reg,
          memoryCleared_reg, 1'b0, missionActive_reg, 1'b0};
        `ADDR_DELAY_LOW: regReadData <= delay_reg[7:0];
        `ADDR_DELAY_MID: regReadData <= delay_reg[15:8];
        `ADDR_DELAY_HIGH: regReadData <= delay_reg[23:16];
        // stamp bytes: seconds, minutes, hours, date, month, year from bit 0 up
        `ADDR_STAMP_SECONDS: regReadData <= stamp_reg[7:0] & `MASK_STAMP_SECONDS;
        `ADDR_STAMP_MINUTES: regReadData <= stamp_reg[15:8] & `MASK_STAMP_MINUTES;
        `ADDR_STAMP_HOURS: regReadData <= stamp_reg[23:16] & `MASK_STAMP_HOURS;
        `ADDR_STAMP_DATE: regReadData <= stamp_reg[31:24] & `MASK_STAMP_DATE;
        `ADDR_STAMP_MONTH: regReadData <= stamp_reg[39:32] & `MASK_STAMP_MONTH;
        `ADDR_STAMP_YEAR: regReadData <= stamp_reg[47:40] & `MASK_STAMP_YEAR;
        default: regReadData <= 8'h00;
      endcase
    end
  end

endmodule // mission_status_registers

//--- rtl/mission_status_defines.vh
// register addresses, fixed bit values and field positions of the mission status bank
`ifndef MISSION_STATUS_DEFINES_VH
`define MISSION_STATUS_DEFINES_VH
`define ADDR_ALARM_FLAGS 10'h214
`define ADDR_MISSION_STATE 10'h215
`define ADDR_DELAY_LOW 10'h216
`define ADDR_DELAY_MID 10'h217
`define ADDR_DELAY_HIGH 10'h218
`define ADDR_STAMP_SECONDS 10'h219
`define ADDR_STAMP_MINUTES 10'h21a
`define ADDR_STAMP_HOURS 10'h21b
`define ADDR_STAMP_DATE 10'h21c
`define ADDR_STAMP_MONTH 10'h21d
`define ADDR_STAMP_YEAR 10'h21e
`define ALARM_FIXED_ONES 8'h70
`define STATE_FIXED_ONES 8'hc0
`define BIT_LOW_TEMP 0
`define BIT_HIGH_TEMP 1
`define BIT_BATTERY_RESET 7
`define BIT_MISSION_ACTIVE 1
`define BIT_MEMORY_CLEARED 3
`define BIT_WAITING_ALARM 4
`define MASK_STAMP_SECONDS 8'h7f
`define MASK_STAMP_MINUTES 8'h7f
`define MASK_STAMP_HOURS 8'h7f
`define MASK_STAMP_DATE 8'h3f
`define MASK_STAMP_MONTH 8'h9f
`define MASK_STAMP_YEAR 8'hff
`endif

//--- test/rtc_model.sv
// real-time clock model that feeds the time bytes
`timescale 1ns/1ps
module rtc_model (
  output reg [47:0] rtcTime
);
  // *****
  // time
  // *****
  // all ones, so every fixed-zero stamp bit is driven high
  initial rtcTime = 48'hffffffffffff;
endmodule // rtc_model

//--- test/mission_status_props.sv
// port assertions for the mission status bank
`timescale 1ns/1ps
`include "mission_status_defines.vh"
module mission_status_props #(
  parameter ADDR_WIDTH = 10
) (
  input wire ref_clk,
  input wire rst,
  input wire powerOnReset,
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire clearMemoryCmd,
  input wire startMissionCmd,
  input wire stopMissionCmd,
  input wire [7:0] regReadData,
  input wire startRefused,
  input wire loggingEnable,
  input wire alarmTestEnable,
  input wire sampleCountClear
);
  // *****
  // checks
  // *****
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // the past-reset guard keeps the read checks quiet on the first edge after release
  alarm_fixed_a: assert property (!$past(rst) && $past(regAddr) == `ADDR_ALARM_FLAGS |-> regReadData[6:2] == 5'h1c)
    else $error("alarm fixed bits wrong");
  state_fixed_a: assert property (!$past(rst) && $past(regAddr) == `ADDR_MISSION_STATE
    |-> {regReadData[7:5], regReadData[2], regReadData[0]} == 5'h18)
    else $error("state fixed bits wrong");
  stamp_zero_a: assert property (!$past(rst) && $past(regAddr) == `ADDR_STAMP_SECONDS |-> !regReadData[7])
    else $error("stamp fixed bit set");
  refuse_cause_a: assert property (startRefused |-> $past(startMissionCmd))
    else $error("refusal without start");
  count_clear_a: assert property (sampleCountClear |-> $past(clearMemoryCmd))
    else $error("count clear without memory clear");
  phase_excl_a: assert property (!(loggingEnable && alarmTestEnable))
    else $error("both phases on");
  stop_end_a: assert property (stopMissionCmd && !startMissionCmd |=> !loggingEnable && !alarmTestEnable)
    else $error("phase after stop");
  battery_flag_a: assert property (powerOnReset && !clearMemoryCmd ##1 regAddr == `ADDR_ALARM_FLAGS && !clearMemoryCmd
    |=> regReadData[7])
    else $error("battery alarm missing");
  cover property (startRefused);
  cover property (loggingEnable);
  cover property (sampleCountClear);
endmodule // mission_status_props
bind mission_status_registers mission_status_props #(.ADDR_WIDTH(ADDR_WIDTH)) props_i (.ref_clk(ref_clk), .rst(rst),
  .powerOnReset(powerOnReset), .regAddr(regAddr), .clearMemoryCmd(clearMemoryCmd), .startMissionCmd(startMissionCmd),
  .stopMissionCmd(stopMissionCmd), .regReadData(regReadData), .startRefused(startRefused),
  .loggingEnable(loggingEnable), .alarmTestEnable(alarmTestEnable), .sampleCountClear(sampleCountClear));

//--- test/tb_mission_status_registers.sv
// self-checking bench for the mission status bank
`timescale 1ns/1ps
`include "mission_status_defines.vh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin numErrors++; $display("[ERR] %0t %h vs %h", $time, g, e); end end
module tb_mission_status_registers;
  reg ref_clk = 0;
  reg rst = 1;
  reg [9:0] regAddr = 0;
  reg regWrite = 0;
  reg [7:0] regWriteData = 0;
  reg [7:0] cmd = 0;
  reg alarmStart = 0;
  reg lowHit = 0;
  reg highHit = 0;
  wire [47:0] rtcTime;
  wire [7:0] regReadData;
  wire startRefused, loggingEnable, alarmTestEnable, sampleCountClear;
  int numErrors = 0;
  int nCompared = 0;
  localparam [47:0] MASKS = {`MASK_STAMP_YEAR, `MASK_STAMP_MONTH, `MASK_STAMP_DATE, `MASK_STAMP_HOURS,
    `MASK_STAMP_MINUTES, `MASK_STAMP_SECONDS};
  // cmd bits: 0 clear, 1 start, 2 stop, 3 minute, 4 sample, 5 conversion, 6 forced, 7 power-on
  mission_status_registers mission_status_registers_i (.ref_clk(ref_clk), .rst(rst), .powerOnReset(cmd[7]),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData), .clearMemoryCmd(cmd[0]),
    .startMissionCmd(cmd[1]), .stopMissionCmd(cmd[2]), .alarmTriggeredStart(alarmStart), .minuteTick(cmd[3]),
    .sampleTick(cmd[4]), .conversionDone(cmd[5]), .forcedConversion(cmd[6]), .lowAlarmHit(lowHit),
    .highAlarmHit(highHit), .rtcTime(rtcTime), .regReadData(regReadData), .startRefused(startRefused),
    .loggingEnable(loggingEnable), .alarmTestEnable(alarmTestEnable), .sampleCountClear(sampleCountClear));
  rtc_model rtc_model_i (.rtcTime(rtcTime));
  always #4 ref_clk = ~ref_clk;
  // *****
  // tasks
  // *****
  task automatic wr(input [9:0] a, input [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrite <= 1'b1;
    regWriteData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // read data answers one cycle after the address
  task automatic rd(input [9:0] a, input [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    @(posedge ref_clk);
    #1 `CHK(regReadData, e)
  endtask
  // one-cycle command pulse; registered answers are visible on return
  task automatic pulse(input [7:0] m);
    @(posedge ref_clk);
    cmd <= m;
    @(posedge ref_clk);
    cmd <= 8'h00;
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d compared %0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // *****
  // tests
  // *****
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`ADDR_ALARM_FLAGS, 8'h70);
    pulse(8'h80);
    wr(`ADDR_ALARM_FLAGS, 8'h0f);
    rd(`ADDR_ALARM_FLAGS, 8'hf0);
    wr(`ADDR_MISSION_STATE, 8'h3f);
    rd(`ADDR_MISSION_STATE, 8'hc0);
    rd(10'h213, 8'h00);
    pulse(8'h02);
    `CHK(startRefused, 1'b1)
    wr(`ADDR_DELAY_MID, 8'ha5);
    wr(`ADDR_DELAY_HIGH, 8'h5a);
    rd(`ADDR_DELAY_MID, 8'ha5);
    rd(`ADDR_DELAY_HIGH, 8'h5a);
    wr(`ADDR_DELAY_MID, 8'h00);
    wr(`ADDR_DELAY_HIGH, 8'h00);
    // a chained logger gets a delay with rollover left off by the host
    wr(`ADDR_DELAY_LOW, 8'h02);
    for (int s = 0; s < 2; s++) begin
      pulse(8'h01);
      `CHK(sampleCountClear, 1'b1)
      rd(`ADDR_ALARM_FLAGS, 8'h70);
      rd(`ADDR_MISSION_STATE, 8'hc8);
      alarmStart <= s[0];
      pulse(8'h02);
      `CHK(startRefused, 1'b0)
      rd(`ADDR_MISSION_STATE, s ? 8'hd2 : 8'hc2);
      wr(`ADDR_DELAY_LOW, 8'hff);
      rd(`ADDR_DELAY_LOW, 8'h02);
      pulse(8'h08);
      `CHK({loggingEnable, alarmTestEnable}, 2'b00)
      pulse(8'h08);
      `CHK({loggingEnable, alarmTestEnable}, {~s[0], s[0]})
      if (s) begin
        highHit <= 1'b1;
        pulse(8'h20);
        highHit <= 1'b0;
        rd(`ADDR_ALARM_FLAGS, 8'h72);
        rd(`ADDR_MISSION_STATE, 8'hc2);
        pulse(8'h10);
        `CHK(loggingEnable, 1'b1)
      end
      lowHit <= 1'b1;
      pulse(8'h20);
      lowHit <= 1'b0;
      rd(`ADDR_ALARM_FLAGS, s ? 8'h73 : 8'h71);
      for (int i = 0; i < 6; i++)
        rd(10'(`ADDR_STAMP_SECONDS + i), MASKS[8*i+:8]);
      pulse(8'h04);
      `CHK(loggingEnable, 1'b0)
      rd(`ADDR_MISSION_STATE, 8'hc0);
    end
    // stale waiting flag survives stop and clear
    pulse(8'h01);
    pulse(8'h02);
    pulse(8'h04);
    pulse(8'h01);
    rd(`ADDR_MISSION_STATE, 8'hd8);
    highHit <= 1'b1;
    pulse(8'h40);
    highHit <= 1'b0;
    rd(`ADDR_MISSION_STATE, 8'hc8);
    rd(`ADDR_ALARM_FLAGS, 8'h72);
    conclude();
  end
  initial begin
    #20000;
    numErrors++;
    conclude();
  end
endmodule // tb_mission_status_registers
